// file: core/pwm_enc_pkg.sv
package pwm_enc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are not all multiples of four, so each is an index.
  localparam logic [7:0] LOW_CFG_INDEX = 8'h55;
  localparam logic [7:0] HIGH_CFG_INDEX = 8'h56;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] LOW_CFG_ADDR = {LOW_CFG_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] HIGH_CFG_ADDR = {HIGH_CFG_INDEX, 2'b00};

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int CNT_W = 7;
  localparam int HC_LSB = 7;
  localparam int LC_LSB = 0;
  localparam int TB_LSB = 14;
  localparam int TB_W = 2;
  localparam logic [15:0] LOW_CFG_RESET = 16'h007f;
  localparam logic [15:0] HIGH_CFG_RESET = 16'h3f80;
  localparam logic [15:0] HIGH_CFG_MASK = 16'h3fff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  // ****************************************************************
  // Time base in master clock periods
  // ****************************************************************
  localparam int TB_CNT_W = 10;
  localparam logic [TB_CNT_W-1:0] TB_LEN_0 = 10'h00f;
  localparam logic [TB_CNT_W-1:0] TB_LEN_1 = 10'h03f;
  localparam logic [TB_CNT_W-1:0] TB_LEN_2 = 10'h0ff;
  localparam logic [TB_CNT_W-1:0] TB_LEN_3 = 10'h3ff;

  typedef enum logic [1:0] {
    TB_16,
    TB_64,
    TB_256,
    TB_1024
  } tb_sel_t;

endpackage

// file: core/pwm_time_base.sv
`timescale 1ns/100ps

// Free-running prescaler giving one tick every 16, 64, 256 or 1024 clocks.
module pwm_time_base (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_sel,
  output logic o_tick
);

  logic [pwm_enc_pkg::TB_CNT_W-1:0] cnt_q;
  logic [pwm_enc_pkg::TB_CNT_W-1:0] last;

  // Terminal count from the select code.
  always_comb begin
    unique case (pwm_enc_pkg::tb_sel_t'(i_sel))
      pwm_enc_pkg::TB_16: last = pwm_enc_pkg::TB_LEN_0;
      pwm_enc_pkg::TB_64: last = pwm_enc_pkg::TB_LEN_1;
      pwm_enc_pkg::TB_256: last = pwm_enc_pkg::TB_LEN_2;
      pwm_enc_pkg::TB_1024: last = pwm_enc_pkg::TB_LEN_3;
    endcase
  end

  // A ">=" compare means a shorter select takes effect without a long wrap.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (cnt_q >= last) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign o_tick = (cnt_q >= last);

endmodule

// file: core/gpio_level_pwm_encoder.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps

// Summary of operation
// - Time base 16, 64, 256, 1024 clocks.
// - Same time base drives pin and encoder.
// - Period equals high plus low, times base.
// - High phase lasts high count times base.
// - Low phase lasts low count times base.
// - Separate count pairs per level, chosen by level.
// - Low level, zero high count: constant low.
// - Low level, both counts zero: constant low.
// - High level, zero low count: constant high.
// - High level, both zero: constant low wins.
// - High config resets to 3f80.
// - Low config resets to 007f.
module gpio_level_pwm_encoder (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [pwm_enc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_pin_level,
  output logic o_encoded_output_pin
);

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic [15:0] low_cfg_q;
  logic [15:0] high_cfg_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic wreq_q;
  logic [15:0] wmask;

  // Byte enables of the low half turned into a bit mask.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd[15:0] & m);
  endfunction

  assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // One wait cycle per access: waitrequest drops for one cycle to close it.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  // Waitrequest has a flop of its own, the inverse of acknowledge, so the bus pin
  // comes straight from a register and carries no inverter delay to the master.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wreq_q <= 1'b1;
    end else begin
      wreq_q <= !((i_avs_read || i_avs_write) && !ack_q);
    end
  end

  assign o_avs_waitrequest = wreq_q;

  // Writes land only at the closing edge; unmapped addresses are ignored.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cfg_q <= pwm_enc_pkg::LOW_CFG_RESET;
      high_cfg_q <= pwm_enc_pkg::HIGH_CFG_RESET;
    end else if (i_avs_write && ack_q) begin
      if (i_avs_address == pwm_enc_pkg::LOW_CFG_ADDR) begin
        low_cfg_q <= merge(low_cfg_q, i_avs_writedata, wmask);
      end
      if (i_avs_address == pwm_enc_pkg::HIGH_CFG_ADDR) begin
        high_cfg_q <= merge(high_cfg_q, i_avs_writedata, wmask)
                      & pwm_enc_pkg::HIGH_CFG_MASK;
      end
    end
  end

  // Read data is prepared while waiting, so it stands at the closing edge.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
    end else if (i_avs_read && !ack_q) begin
      if (i_avs_address == pwm_enc_pkg::LOW_CFG_ADDR) begin
        rdata_q <= {16'h0000, low_cfg_q};
      end else if (i_avs_address == pwm_enc_pkg::HIGH_CFG_ADDR) begin
        rdata_q <= {16'h0000, high_cfg_q & pwm_enc_pkg::HIGH_CFG_MASK};
      end else begin
        rdata_q <= '0;
      end
    end
  end

  assign o_avs_readdata = rdata_q;

  // ****************************************************************
  // Time base
  // ****************************************************************
  logic tick;

  // One prescaler serves both the pin pattern and the encoder.
  pwm_time_base u_tb (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_sel(low_cfg_q[pwm_enc_pkg::TB_LSB +: pwm_enc_pkg::TB_W]),
    .o_tick(tick)
  );

  // ****************************************************************
  // Pattern generator
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_CONST,
    ST_HIGH,
    ST_LOW
  } phase_t;

  phase_t phase_q;
  logic [pwm_enc_pkg::CNT_W-1:0] hc_sel;
  logic [pwm_enc_pkg::CNT_W-1:0] lc_sel;
  logic [pwm_enc_pkg::CNT_W-1:0] lc_q;
  logic [pwm_enc_pkg::CNT_W-1:0] cnt_q;
  logic const_lvl;
  logic is_const;
  logic pin_q;

  // Count pair picked by the level being signalled.
  assign hc_sel = i_pin_level ? high_cfg_q[pwm_enc_pkg::HC_LSB +: pwm_enc_pkg::CNT_W]
                              : low_cfg_q[pwm_enc_pkg::HC_LSB +: pwm_enc_pkg::CNT_W];
  assign lc_sel = i_pin_level ? high_cfg_q[pwm_enc_pkg::LC_LSB +: pwm_enc_pkg::CNT_W]
                              : low_cfg_q[pwm_enc_pkg::LC_LSB +: pwm_enc_pkg::CNT_W];

  // Static cases: zero high count is low; zero low count is high.
  always_comb begin
    if (hc_sel == pwm_enc_pkg::CNT_ZERO) begin
      is_const = 1'b1;
      const_lvl = 1'b0;
    end else if (lc_sel == pwm_enc_pkg::CNT_ZERO) begin
      is_const = 1'b1;
      const_lvl = 1'b1;
    end else begin
      is_const = 1'b0;
      const_lvl = 1'b0;
    end
  end

  // Counts are latched at a period boundary only, so mid-period count writes
  // never tear a pattern; static levels follow at once.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= ST_CONST;
      cnt_q <= pwm_enc_pkg::CNT_ZERO;
      lc_q <= pwm_enc_pkg::CNT_ZERO;
    end else begin
      unique case (phase_q)
        ST_CONST: begin
          if (!is_const && tick) begin
            phase_q <= ST_HIGH;
            cnt_q <= hc_sel;
            lc_q <= lc_sel;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            if (cnt_q == pwm_enc_pkg::CNT_ONE) begin
              phase_q <= ST_LOW;
              cnt_q <= lc_q;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
        ST_LOW: begin
          if (tick) begin
            if (cnt_q == pwm_enc_pkg::CNT_ONE) begin
              if (is_const) begin
                phase_q <= ST_CONST;
              end else begin
                phase_q <= ST_HIGH;
                cnt_q <= hc_sel;
                lc_q <= lc_sel;
              end
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Registered pin: static levels take over immediately.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_q <= 1'b0;
    end else if (is_const) begin
      pin_q <= const_lvl;
    end else begin
      pin_q <= (phase_q == ST_HIGH);
    end
  end

  assign o_encoded_output_pin = pin_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // An access closes in one cycle of acknowledge; a second would commit a write twice.
  // The acknowledge check below is built from these steps.
  sequence s_access_closes;
    ack_q ##1 !ack_q;
  endsequence

  a_bus_ack_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ack_q |-> s_access_closes)
    else $error("Acknowledge lasted more than one cycle.");

  a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    high_cfg_q[15:14] == 2'b00)
    else $error("Reserved bits of high config are set.");

  a_low_static: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!i_pin_level && hc_sel == pwm_enc_pkg::CNT_ZERO) |=> !o_encoded_output_pin)
    else $error("Static low level not output.");

  a_high_static: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_pin_level && lc_sel == pwm_enc_pkg::CNT_ZERO && hc_sel != pwm_enc_pkg::CNT_ZERO)
    |=> o_encoded_output_pin)
    else $error("Static high level not output.");

  a_both_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (hc_sel == pwm_enc_pkg::CNT_ZERO && lc_sel == pwm_enc_pkg::CNT_ZERO)
    |=> !o_encoded_output_pin)
    else $error("Both-zero counts did not give low.");

  a_phase_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (phase_q == ST_HIGH && !tick) |=> (phase_q == ST_HIGH && $stable(cnt_q)))
    else $error("High phase moved without a tick.");

  a_high_to_low: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (phase_q == ST_HIGH && tick && cnt_q == pwm_enc_pkg::CNT_ONE)
    |=> (phase_q == ST_LOW && cnt_q == $past(lc_q)))
    else $error("High phase did not hand over to low.");

  a_tick_spacing: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (tick && $stable(low_cfg_q[15:14])) |=> !tick [*8])
    else $error("Time base ticks too close together.");

  // A full-word write to the low config lands at the edge where acknowledge stands.
  sequence s_low_write;
    i_avs_write && ack_q && i_avs_address == pwm_enc_pkg::LOW_CFG_ADDR
      && (&i_avs_byteenable[1:0]);
  endsequence

  a_wr_commit: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    s_low_write |=> (low_cfg_q == $past(i_avs_writedata[15:0])))
    else $error("Low config write did not land.");

  // Outside a closing write edge neither configuration word may move.
  a_cfg_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !(i_avs_write && ack_q) |=> ($stable(low_cfg_q) && $stable(high_cfg_q)))
    else $error("Configuration changed without a bus write.");

  // The waitrequest flop must always mirror the acknowledge flop.
  a_wreq_mirror: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_avs_waitrequest == !ack_q)
    else $error("Waitrequest does not mirror acknowledge.");

  // Reading the high config never shows the reserved bits or the unused half.
  a_read_high: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_avs_read && !ack_q && i_avs_address == pwm_enc_pkg::HIGH_CFG_ADDR)
    |=> (o_avs_readdata[31:14] == '0))
    else $error("Reserved bits of high config read as set.");

  // ****************************************************************
  // Pattern checks
  // ****************************************************************
  // The pin lags the phase register by one cycle while a pattern runs.
  a_pin_high: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!is_const && phase_q == ST_HIGH) |=> o_encoded_output_pin)
    else $error("Pin low during the high phase.");

  a_pin_low: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!is_const && phase_q == ST_LOW) |=> !o_encoded_output_pin)
    else $error("Pin high during the low phase.");

  a_low_to_high: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (phase_q == ST_LOW && tick && cnt_q == pwm_enc_pkg::CNT_ONE && !is_const)
    |=> (phase_q == ST_HIGH && cnt_q == $past(hc_sel)))
    else $error("Low phase did not start a new period.");

  // The low count of a running period is never replaced during its high phase.
  a_latch_boundary: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (phase_q == ST_HIGH) |=> $stable(lc_q))
    else $error("Low count changed inside a period.");

  // A static level keeps the pattern generator parked.
  a_const_stay: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (phase_q == ST_CONST && is_const) |=> (phase_q == ST_CONST))
    else $error("Pattern started while the level is static.");

endmodule

// file: testbench/pin_sensor.sv
`timescale 1ns/100ps

// Stands in for the external circuit that senses the encoded pin.
// It reports the length, in clocks, of the last high run and the last low run.
module pin_sensor (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic [15:0] o_high_len,
  output logic [15:0] o_low_len
);
  logic [15:0] run_q;
  logic pin_q;

  // A run is stored only when it ends, so a static pin leaves both lengths alone.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_q <= 16'h0000;
      pin_q <= 1'b0;
      o_high_len <= 16'h0000;
      o_low_len <= 16'h0000;
    end else begin
      pin_q <= i_pin;
      if (i_pin !== pin_q) begin
        run_q <= 16'h0001;
        if (pin_q) begin
          o_high_len <= run_q;
        end else begin
          o_low_len <= run_q;
        end
      end else begin
        run_q <= run_q + 16'h0001;
      end
    end
  end
endmodule

// file: testbench/gpio_level_pwm_encoder_bench.sv
`timescale 1ns/100ps

module gpio_level_pwm_encoder_bench;
  localparam logic [9:0] LO_A = pwm_enc_pkg::LOW_CFG_ADDR;
  localparam logic [9:0] HI_A = pwm_enc_pkg::HIGH_CFG_ADDR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  logic level = 1'b0;
  logic pin;
  logic [15:0] high_len;
  logic [15:0] low_len;
  int bad_count = 0;
  int checks_done = 0;

  gpio_level_pwm_encoder uut (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h3),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_pin_level(level),
    .o_encoded_output_pin(pin));
  pin_sensor sense (.i_sys_clk(clk), .i_rstn(rstn), .i_pin(pin), .o_high_len(high_len),
    .o_low_len(low_len));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request is held until waitrequest is sampled low; only the watchdog ends a hang.
  // One wait state means two edges per access: one sees the request, one closes it.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check("access edges", 32'h00000002, n);
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 16'h0000, q);
    check(what, exp, q);
  endtask

  // Waiting past two full periods lets the sensor hold only steady-state runs.
  task automatic runs(input int cycles, input int hi, input int lo);
    repeat (cycles) @(posedge clk);
    check("high run", hi, {16'h0000, high_len});
    check("low run", lo, {16'h0000, low_len});
  endtask

  // A static level must not move over a span longer than the 64-clock test periods at the 16-clock base.
  task automatic steady(input logic exp);
    repeat (20) @(posedge clk);
    check("pin", {31'h0, exp}, {31'h0, pin});
    repeat (300) @(posedge clk);
    check("pin held", {31'h0, exp}, {31'h0, pin});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd_chk("high cfg", HI_A, 32'h00003f80);
    rd_chk("low cfg", LO_A, 32'h0000007f);
    steady(1'b0);
    level <= 1'b1;
    steady(1'b1);
    level <= 1'b0;
    $display("Test reset done");
  endtask

  task automatic t_regs;
    wr_reg(HI_A, 16'hffff);
    rd_chk("reserved bits", HI_A, 32'h00003fff);
    wr_reg(10'h000, 16'h1234);
    rd_chk("unmapped", 10'h000, 32'h00000000);
    wr_reg(HI_A, 16'h3f80);
    $display("Test registers done");
  endtask

  task automatic t_base;
    int b;
    for (int i = 0; i < 4; i++) begin
      b = 16 << (2 * i);
      wr_reg(LO_A, {i[1:0], 7'h01, 7'h02});
      runs(12 * b, b, 2 * b);
    end
    $display("Test time base done");
  endtask

  task automatic t_levels;
    wr_reg(LO_A, 16'h0005);
    level <= 1'b1;
    wr_reg(HI_A, 16'h0181);
    runs(400, 48, 16);
    wr_reg(HI_A, 16'h0280);
    steady(1'b1);
    wr_reg(HI_A, 16'h0000);
    steady(1'b0);
    level <= 1'b0;
    steady(1'b0);
    wr_reg(LO_A, 16'h0000);
    steady(1'b0);
    $display("Test levels done");
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The clock runs at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end

  // The longest test needs about 16300 clocks, so 40000 means a hang.
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_base();
    t_levels();
    close_out();
  end
endmodule
